// File: design/pdm_pkg.sv
// package: register map, field layout, timing counts and types of the power-down controller
package pdm_pkg;

  // ==========================================================
  // register map
  localparam logic [15:0] PDM_POWER_SYSTEM_CONTROL_ADDR = 16'hFFC4;
  localparam logic [15:0] PDM_POWER_STATUS_ADDR         = 16'hFFC8;
  localparam logic [7:0]  PDM_POWER_SYSTEM_CONTROL_RST  = 8'h09;
  // writable bits; bit 3 is reserved and reads one
  localparam logic [7:0]  PDM_POWER_SYSTEM_CONTROL_WMASK = 8'hF7;

  // ==========================================================
  // field positions of power_system_control
  localparam int unsigned PDM_STANDBY_SELECT_BIT      = 7;
  localparam int unsigned PDM_SETTLE_SEL_HI_BIT       = 6;
  localparam int unsigned PDM_SETTLE_SEL_MID_BIT      = 5;
  localparam int unsigned PDM_SETTLE_SEL_LO_BIT       = 4;
  localparam int unsigned PDM_NONMASK_EDGE_SELECT_BIT = 2;
  localparam int unsigned PDM_DUAL_PORT_MEM_EN_BIT    = 1;
  localparam int unsigned PDM_ONCHIP_RAM_EN_BIT       = 0;

  // ==========================================================
  // settling counts in states (system clock cycles)
  localparam int unsigned PDM_SETTLE_W        = 18;
  localparam int unsigned PDM_SETTLE_STATES_0 = 8192;
  localparam int unsigned PDM_SETTLE_STATES_1 = 16384;
  localparam int unsigned PDM_SETTLE_STATES_2 = 32768;
  localparam int unsigned PDM_SETTLE_STATES_3 = 65536;
  localparam int unsigned PDM_SETTLE_STATES_4 = 131072;

  // ==========================================================
  // operating states
  typedef enum logic [2:0] {
    PDM_ST_RUN,
    PDM_ST_SLEEP,
    PDM_ST_SW_STANDBY,
    PDM_ST_SETTLE,
    PDM_ST_RESET,
    PDM_ST_HW_STANDBY,
    PDM_ST_HW_WAKE
  } pdm_state_t;

  // wake source codes
  localparam logic [2:0] PDM_WAKE_NONE   = 3'h0;
  localparam logic [2:0] PDM_WAKE_NMI    = 3'h1;
  localparam logic [2:0] PDM_WAKE_REQ0   = 3'h2;
  localparam logic [2:0] PDM_WAKE_REQ1   = 3'h3;
  localparam logic [2:0] PDM_WAKE_REQ2   = 3'h4;
  localparam logic [2:0] PDM_WAKE_PERIPH = 3'h5;

  // ==========================================================
  // synchronised pin bundle (all active low)
  typedef struct packed {
    logic       nmi_n;
    logic [2:0] req_n;
    logic       reset_n;
    logic       hw_standby_pin_n_n;
  } pdm_pins_t;

  // clock and control lines driven by the controller
  typedef struct packed {
    logic cpu_clk_en;
    logic periph_clk_en;
    logic osc_run;
    logic periph_init;
    logic cpu_reset;
    logic port_hold;
    logic port_hiz;
  } pdm_ctl_t;

endpackage : pdm_pkg

// File: design/pdm_pin_sync.sv
// module: two-flop synchroniser for the external pin bundle
`timescale 1ns/100ps
module pdm_pin_sync (
  input  wire logic              clk_in,
  input  wire logic              reset_n_in,
  input  wire pdm_pkg::pdm_pins_t pins_in,
  output logic                   [$bits(pdm_pkg::pdm_pins_t)-1:0] pins_out
);

  typedef struct packed {
    pdm_pkg::pdm_pins_t meta;
    pdm_pkg::pdm_pins_t sync;
  } pdm_sync_state_t;

  pdm_sync_state_t s_q;
  pdm_sync_state_t s_d;

  // ==========================================================
  // next state; pins idle high
  always_comb
  begin
    s_d      = s_q;
    s_d.meta = pins_in;
    s_d.sync = s_q.meta;
  end

  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
    begin
      s_q <= '1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign pins_out = s_q.sync;

endmodule : pdm_pin_sync

// File: design/pdm_settle_timer.sv
// module: oscillator settling counter, one count per system clock cycle
`timescale 1ns/100ps
module pdm_settle_timer #(
  parameter int unsigned WIDTH = pdm_pkg::PDM_SETTLE_W
) (
  input  wire logic             clk_in,
  input  wire logic             reset_n_in,
  input  wire logic             start_in,
  input  wire logic [WIDTH-1:0] load_in,
  output logic                  busy_out,
  output logic                  done_out
);

  typedef struct packed {
    logic [WIDTH-1:0] cnt;
    logic             busy;
    logic             done;
  } pdm_timer_state_t;

  pdm_timer_state_t s_q;
  pdm_timer_state_t s_d;

  // ==========================================================
  // done pulses load_in+1 cycles after start
  always_comb
  begin
    s_d      = s_q;
    s_d.done = 1'b0;
    if (start_in)
    begin
      s_d.cnt  = load_in;
      s_d.busy = 1'b1;
    end
    else if (s_q.busy)
    begin
      if (s_q.cnt <= WIDTH'(1))
      begin
        s_d.busy = 1'b0;
        s_d.done = 1'b1;
        s_d.cnt  = '0;
      end
      else
      begin
        s_d.cnt = s_q.cnt - WIDTH'(1);
      end
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign busy_out = s_q.busy;
  assign done_out = s_q.done;

endmodule : pdm_settle_timer

// File: design/pdm_ctrl.sv
// module: power-down mode controller with system control register on APB
//
// Notes on behaviour
// - sleep instruction enters sleep when standby select is 0, else software standby
// - standby select stays 1 after external-interrupt wake; a write, the reset state or hardware standby clears it
// - settle field picks 8192, 16384, 32768, 65536 or 131072 states
// - during settling oscillator runs, CPU and peripheral clocks stay off
// - in sleep the CPU halts with registers held, peripherals keep running
// - enabled interrupt during sleep ends sleep and starts interrupt handling
// - disabled peripheral requests never wake; masked CPU wakes only on NMI
// - reset pin low during sleep goes straight to the reset state
// - hardware standby pin low during sleep enters hardware standby
// - software standby stops clocks, initialises peripherals, keeps CPU and RAM
// - NMI or requests 0 to 2 wake standby after settling, then handler runs
// - reset pin low in standby runs clocks; on release reset and select reads 0
// - hardware standby pin low during software standby enters hardware standby
// - I/O ports hold output and direction throughout software standby
// - NMI edge select: 0 falling, 1 rising, also for standby wake
// - standby pin low from any state enters hardware standby; exit needs reset rise
//
// Decided for this implementation: the APB register port.
`timescale 1ns/100ps
module pdm_ctrl #(
  parameter int unsigned SETTLE_STATES_0 = pdm_pkg::PDM_SETTLE_STATES_0,
  parameter int unsigned SETTLE_STATES_1 = pdm_pkg::PDM_SETTLE_STATES_1,
  parameter int unsigned SETTLE_STATES_2 = pdm_pkg::PDM_SETTLE_STATES_2,
  parameter int unsigned SETTLE_STATES_3 = pdm_pkg::PDM_SETTLE_STATES_3,
  parameter int unsigned SETTLE_STATES_4 = pdm_pkg::PDM_SETTLE_STATES_4
) (
  input  wire logic        CLK_IN,
  input  wire logic        RESET_N_IN,
  // apb slave
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [15:0] PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  input  wire logic [3:0]  PSTRB_IN,
  output logic      [31:0] PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  // cpu side
  input  wire logic        SLEEP_EXEC_IN,
  input  wire logic        CPU_IMASK_IN,
  input  wire logic        PERIPH_IRQ_IN,
  input  wire logic [2:0]  EXT_REQ_ENABLE_IN,
  // external pins, active low
  input  wire logic        NMI_PIN_N_IN,
  input  wire logic [2:0]  EXT_REQUEST_N_IN,
  input  wire logic        RESET_PIN_N_IN,
  input  wire logic        HW_STANDBY_PIN_N_IN,
  // clock and mode control
  output logic             CPU_CLK_EN_OUT,
  output logic             PERIPH_CLK_EN_OUT,
  output logic             OSC_RUN_OUT,
  output logic             PERIPH_INIT_OUT,
  output logic             CPU_RESET_OUT,
  output logic             PORT_HOLD_OUT,
  output logic             PORT_HIZ_OUT,
  output logic             WAKE_PULSE_OUT,
  output logic      [2:0]  WAKE_SRC_OUT,
  output logic             NMI_EDGE_OUT,
  output logic             RAM_ENABLE_OUT,
  output logic             DUAL_PORT_MEM_ENABLE_OUT,
  output logic      [2:0]  MODE_OUT
);

  localparam int unsigned SW = pdm_pkg::PDM_SETTLE_W;

  typedef struct packed {
    pdm_pkg::pdm_state_t st;
    logic [7:0]          sysctl;
    logic [2:0]          wake_src;
    logic                imask_at_sleep;
    logic                nmi_prev;
    logic                res_seen_low;
    logic                settle_start;
    logic                wake_pulse;
    logic                nmi_edge;
    pdm_pkg::pdm_ctl_t   ctl;
    logic                pready;
    logic                pslverr;
    logic [31:0]         prdata;
  } pdm_ctrl_state_t;

  pdm_ctrl_state_t    s_q;
  pdm_ctrl_state_t    s_d;
  pdm_pkg::pdm_pins_t pins_raw;
  logic [$bits(pdm_pkg::pdm_pins_t)-1:0] pins_bits;
  pdm_pkg::pdm_pins_t pins;
  logic               settle_busy;
  logic               settle_done;
  logic [SW-1:0]      settle_load;

  // ==========================================================
  // helper functions
  function automatic logic [SW-1:0] settle_count(input logic [2:0] sel);
    logic [SW-1:0] n;
    n = SW'(SETTLE_STATES_4);
    if (!sel[2])
    begin
      case (sel[1:0])
        2'h0:    n = SW'(SETTLE_STATES_0);
        2'h1:    n = SW'(SETTLE_STATES_1);
        2'h2:    n = SW'(SETTLE_STATES_2);
        default: n = SW'(SETTLE_STATES_3);
      endcase
    end
    return n;
  endfunction : settle_count

  // highest priority request: NMI, then requests 0..2, then peripheral
  function automatic logic [2:0] pick_src(input logic       nmi,
                                          input logic [2:0] req,
                                          input logic       periph);
    logic [2:0] src;
    src = pdm_pkg::PDM_WAKE_NONE;
    if (nmi)
      src = pdm_pkg::PDM_WAKE_NMI;
    else if (req[0])
      src = pdm_pkg::PDM_WAKE_REQ0;
    else if (req[1])
      src = pdm_pkg::PDM_WAKE_REQ1;
    else if (req[2])
      src = pdm_pkg::PDM_WAKE_REQ2;
    else if (periph)
      src = pdm_pkg::PDM_WAKE_PERIPH;
    return src;
  endfunction : pick_src

  function automatic pdm_pkg::pdm_ctl_t ctl_of(input pdm_pkg::pdm_state_t st);
    pdm_pkg::pdm_ctl_t c;
    // bits: cpu, periph, osc, init, reset, hold, hiz
    c = pdm_pkg::pdm_ctl_t'(7'h70);
    case (st)
      pdm_pkg::PDM_ST_SLEEP:      c.cpu_clk_en = 1'b0;
      pdm_pkg::PDM_ST_SW_STANDBY: c = pdm_pkg::pdm_ctl_t'(7'h0A);
      pdm_pkg::PDM_ST_SETTLE:     c = pdm_pkg::pdm_ctl_t'(7'h1A);
      pdm_pkg::PDM_ST_RESET:      c = pdm_pkg::pdm_ctl_t'(7'h7C);
      pdm_pkg::PDM_ST_HW_STANDBY: c = pdm_pkg::pdm_ctl_t'(7'h0D);
      pdm_pkg::PDM_ST_HW_WAKE:    c = pdm_pkg::pdm_ctl_t'(7'h1D);
      default:                    c = pdm_pkg::pdm_ctl_t'(7'h70);
    endcase
    return c;
  endfunction : ctl_of

  // ==========================================================
  // pin synchroniser and settling timer
  assign pins_raw = '{nmi_n: NMI_PIN_N_IN, req_n: EXT_REQUEST_N_IN,
                      reset_n: RESET_PIN_N_IN, hw_standby_pin_n_n: HW_STANDBY_PIN_N_IN};
  assign pins     = pdm_pkg::pdm_pins_t'(pins_bits);

  pdm_pin_sync u_pin_sync (
    .clk_in     (CLK_IN),
    .reset_n_in (RESET_N_IN),
    .pins_in    (pins_raw),
    .pins_out   (pins_bits)
  );

  assign settle_load = settle_count(s_q.sysctl[pdm_pkg::PDM_SETTLE_SEL_HI_BIT:
                                               pdm_pkg::PDM_SETTLE_SEL_LO_BIT]);

  pdm_settle_timer #(
    .WIDTH (SW)
  ) u_settle_timer (
    .clk_in     (CLK_IN),
    .reset_n_in (RESET_N_IN),
    .start_in   (s_q.settle_start),
    .load_in    (settle_load),
    .busy_out   (settle_busy),
    .done_out   (settle_done)
  );

  // ==========================================================
  // next state
  always_comb
  begin
    logic       nmi_hit;
    logic [2:0] req_hit;
    logic       periph_hit;
    logic [2:0] src;
    logic       acc;
    logic       reg_ctl;
    logic       reg_sts;
    nmi_hit    = 1'b0;
    req_hit    = 3'h0;
    periph_hit = 1'b0;
    src        = pdm_pkg::PDM_WAKE_NONE;
    acc        = PSEL_IN && PENABLE_IN;
    reg_ctl    = 1'b0;
    reg_sts    = 1'b0;
    s_d        = s_q;

    s_d.settle_start = 1'b0;
    s_d.wake_pulse   = 1'b0;
    s_d.nmi_prev     = pins.nmi_n;

    // nmi edge of the selected polarity
    if (s_q.sysctl[pdm_pkg::PDM_NONMASK_EDGE_SELECT_BIT])
      nmi_hit = !s_q.nmi_prev && pins.nmi_n;
    else
      nmi_hit = s_q.nmi_prev && !pins.nmi_n;
    s_d.nmi_edge = nmi_hit && (s_q.st == pdm_pkg::PDM_ST_RUN);
    req_hit = ~pins.req_n & EXT_REQ_ENABLE_IN;

    // ---------------- apb register access
    if (PADDR_IN == pdm_pkg::PDM_POWER_SYSTEM_CONTROL_ADDR)
      reg_ctl = 1'b1;
    else if (PADDR_IN == pdm_pkg::PDM_POWER_STATUS_ADDR)
      reg_sts = 1'b1;
    s_d.pready = 1'b0;
    if (acc && !s_q.pready)
    begin
      s_d.pready  = 1'b1;
      s_d.pslverr = !(reg_ctl || reg_sts);
      s_d.prdata  = 32'h0000_0000;
      if (!PWRITE_IN && reg_ctl)
        s_d.prdata = {24'h00_0000, s_q.sysctl};
      else if (!PWRITE_IN && reg_sts)
        s_d.prdata = {20'h0_0000, settle_busy, s_q.wake_src, 5'h00, s_q.st};
    end
    if (acc && s_q.pready && PWRITE_IN && reg_ctl && PSTRB_IN[0])
      s_d.sysctl = (PWDATA_IN[7:0] & pdm_pkg::PDM_POWER_SYSTEM_CONTROL_WMASK)
                 | (pdm_pkg::PDM_POWER_SYSTEM_CONTROL_RST
                    & ~pdm_pkg::PDM_POWER_SYSTEM_CONTROL_WMASK);

    // ---------------- mode sequencing
    case (s_q.st)
      pdm_pkg::PDM_ST_RUN:
      begin
        if (SLEEP_EXEC_IN)
        begin
          s_d.imask_at_sleep = CPU_IMASK_IN;
          if (s_q.sysctl[pdm_pkg::PDM_STANDBY_SELECT_BIT])
            s_d.st = pdm_pkg::PDM_ST_SW_STANDBY;
          else
            s_d.st = pdm_pkg::PDM_ST_SLEEP;
        end
      end
      pdm_pkg::PDM_ST_SLEEP:
      begin
        periph_hit = PERIPH_IRQ_IN && !s_q.imask_at_sleep;
        src = pick_src(nmi_hit, s_q.imask_at_sleep ? 3'h0 : req_hit, periph_hit);
        if (src != pdm_pkg::PDM_WAKE_NONE)
        begin
          s_d.st         = pdm_pkg::PDM_ST_RUN;
          s_d.wake_src   = src;
          s_d.wake_pulse = 1'b1;
        end
      end
      pdm_pkg::PDM_ST_SW_STANDBY:
      begin
        src = pick_src(nmi_hit, s_q.imask_at_sleep ? 3'h0 : req_hit, 1'b0);
        if (src != pdm_pkg::PDM_WAKE_NONE)
        begin
          s_d.st           = pdm_pkg::PDM_ST_SETTLE;
          s_d.wake_src     = src;
          s_d.settle_start = 1'b1;
        end
      end
      pdm_pkg::PDM_ST_SETTLE:
      begin
        if (settle_done)
        begin
          s_d.st         = pdm_pkg::PDM_ST_RUN;
          s_d.wake_pulse = 1'b1;
        end
      end
      pdm_pkg::PDM_ST_RESET:
      begin
        s_d.sysctl = pdm_pkg::PDM_POWER_SYSTEM_CONTROL_RST;
        if (pins.reset_n)
          s_d.st = pdm_pkg::PDM_ST_RUN;
      end
      pdm_pkg::PDM_ST_HW_STANDBY:
      begin
        s_d.sysctl       = pdm_pkg::PDM_POWER_SYSTEM_CONTROL_RST;
        s_d.res_seen_low = 1'b0;
        if (pins.hw_standby_pin_n_n)
          s_d.st = pdm_pkg::PDM_ST_HW_WAKE;
      end
      pdm_pkg::PDM_ST_HW_WAKE:
      begin
        s_d.sysctl = pdm_pkg::PDM_POWER_SYSTEM_CONTROL_RST;
        if (!pins.reset_n)
          s_d.res_seen_low = 1'b1;
        else if (s_q.res_seen_low)
          s_d.st = pdm_pkg::PDM_ST_RUN;
      end
      default:
      begin
        s_d.st = pdm_pkg::PDM_ST_RUN;
      end
    endcase

    // reset pin outranks every software mode
    if (!pins.reset_n && (s_q.st == pdm_pkg::PDM_ST_RUN || s_q.st == pdm_pkg::PDM_ST_SLEEP
        || s_q.st == pdm_pkg::PDM_ST_SW_STANDBY || s_q.st == pdm_pkg::PDM_ST_SETTLE))
    begin
      s_d.st           = pdm_pkg::PDM_ST_RESET;
      s_d.wake_pulse   = 1'b0;
      s_d.settle_start = 1'b0;
    end
    // standby pin outranks everything
    if (!pins.hw_standby_pin_n_n)
    begin
      s_d.st           = pdm_pkg::PDM_ST_HW_STANDBY;
      s_d.wake_pulse   = 1'b0;
      s_d.settle_start = 1'b0;
      s_d.nmi_edge     = 1'b0;
    end

    s_d.ctl = ctl_of(s_d.st);
  end

  // ==========================================================
  // state register
  always_ff @(posedge CLK_IN)
  begin
    if (!RESET_N_IN)
    begin
      s_q          <= '0;
      s_q.st       <= pdm_pkg::PDM_ST_RUN;
      s_q.sysctl   <= pdm_pkg::PDM_POWER_SYSTEM_CONTROL_RST;
      s_q.nmi_prev <= 1'b1;
      s_q.ctl      <= ctl_of(pdm_pkg::PDM_ST_RUN);
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // outputs
  assign PRDATA_OUT               = s_q.prdata;
  assign PREADY_OUT               = s_q.pready;
  assign PSLVERR_OUT              = s_q.pslverr && s_q.pready;
  assign CPU_CLK_EN_OUT           = s_q.ctl.cpu_clk_en;
  assign PERIPH_CLK_EN_OUT        = s_q.ctl.periph_clk_en;
  assign OSC_RUN_OUT              = s_q.ctl.osc_run;
  assign PERIPH_INIT_OUT          = s_q.ctl.periph_init;
  assign CPU_RESET_OUT            = s_q.ctl.cpu_reset;
  assign PORT_HOLD_OUT            = s_q.ctl.port_hold;
  assign PORT_HIZ_OUT             = s_q.ctl.port_hiz;
  assign WAKE_PULSE_OUT           = s_q.wake_pulse;
  assign WAKE_SRC_OUT             = s_q.wake_src;
  assign NMI_EDGE_OUT             = s_q.nmi_edge;
  assign RAM_ENABLE_OUT           = s_q.sysctl[pdm_pkg::PDM_ONCHIP_RAM_EN_BIT];
  assign DUAL_PORT_MEM_ENABLE_OUT = s_q.sysctl[pdm_pkg::PDM_DUAL_PORT_MEM_EN_BIT];
  assign MODE_OUT                 = s_q.st;

endmodule : pdm_ctrl

// File: sim/pdm_ctrl_sva.sv
// checker: modes, clock gating, settle length and bus answer
`timescale 1ns/100ps
module pdm_ctrl_sva #(
  parameter int unsigned SETTLE_STATES_0 = 8,
  parameter int unsigned SETTLE_STATES_1 = 16,
  parameter int unsigned SETTLE_STATES_2 = 32,
  parameter int unsigned SETTLE_STATES_3 = 64,
  parameter int unsigned SETTLE_STATES_4 = 128
) (
  input wire logic        CLK_IN,
  input wire logic        RESET_N_IN,
  input wire logic        PSEL_IN,
  input wire logic        PENABLE_IN,
  input wire logic        PWRITE_IN,
  input wire logic [15:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic [3:0]  PSTRB_IN,
  input wire logic        PREADY_OUT,
  input wire logic        RESET_PIN_N_IN,
  input wire logic        HW_STANDBY_PIN_N_IN,
  input wire logic        CPU_CLK_EN_OUT,
  input wire logic        PERIPH_CLK_EN_OUT,
  input wire logic        OSC_RUN_OUT,
  input wire logic        PERIPH_INIT_OUT,
  input wire logic        PORT_HOLD_OUT,
  input wire logic        PORT_HIZ_OUT,
  input wire logic        WAKE_PULSE_OUT,
  input wire logic [2:0]  MODE_OUT
);
  typedef struct packed {
    logic [2:0]  sel;
    logic [17:0] cnt;
  } pdm_chk_t;
  pdm_chk_t    s_q;
  pdm_chk_t    s_d;
  int unsigned exp_w;
  // ==========
  // settle select shadow and settle cycle count
  always_comb
  begin
    s_d = s_q;
    s_d.cnt = (MODE_OUT == 3'h3) ? s_q.cnt + 18'h1 : 18'h0;
    if (PSEL_IN && PENABLE_IN && PWRITE_IN && PREADY_OUT && PSTRB_IN[0]
        && PADDR_IN == 16'hFFC4)
      s_d.sel = PWDATA_IN[6:4];
    if (MODE_OUT > 3'h3)
      s_d.sel = 3'h0;
    case (s_q.sel)
      3'h0: exp_w = SETTLE_STATES_0;
      3'h1: exp_w = SETTLE_STATES_1;
      3'h2: exp_w = SETTLE_STATES_2;
      3'h3: exp_w = SETTLE_STATES_3;
      default: exp_w = SETTLE_STATES_4;
    endcase
  end
  always_ff @(posedge CLK_IN)
    if (!RESET_N_IN)
      s_q <= '0;
    else
      s_q <= s_d;
  // ==========
  // properties
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RESET_N_IN);
  sequence settle_exit_s;
    MODE_OUT == 3'h3 ##1 MODE_OUT == 3'h0;
  endsequence
  settle_len_a :
    assert property (settle_exit_s |-> 32'(s_q.cnt) == exp_w + 32'h2 && WAKE_PULSE_OUT)
    else $error("settle length wrong");
  sleep_gate_a :
    assert property (MODE_OUT == 3'h1 |-> !CPU_CLK_EN_OUT && PERIPH_CLK_EN_OUT && OSC_RUN_OUT)
    else $error("sleep clocks wrong");
  standby_halt_a :
    assert property (MODE_OUT == 3'h2 |-> !CPU_CLK_EN_OUT && !PERIPH_CLK_EN_OUT
                     && !OSC_RUN_OUT && PERIPH_INIT_OUT && PORT_HOLD_OUT)
    else $error("standby clocks wrong");
  settle_gate_a :
    assert property (MODE_OUT == 3'h3 |-> OSC_RUN_OUT && !CPU_CLK_EN_OUT
                     && !PERIPH_CLK_EN_OUT && PORT_HOLD_OUT)
    else $error("settle clocks wrong");
  hw_entry_a :
    assert property (!HW_STANDBY_PIN_N_IN [*4] |=> MODE_OUT == 3'h5 && PORT_HIZ_OUT)
    else $error("no hardware standby");
  reset_entry_a :
    assert property ((!RESET_PIN_N_IN && HW_STANDBY_PIN_N_IN && MODE_OUT < 3'h5) [*4]
                     |=> MODE_OUT == 3'h4 && CPU_CLK_EN_OUT && OSC_RUN_OUT)
    else $error("no reset state");
  wake_cause_a :
    assert property (WAKE_PULSE_OUT |-> MODE_OUT == 3'h0
                     && $past(MODE_OUT) inside {3'h1, 3'h3} ##1 !WAKE_PULSE_OUT)
    else $error("wake pulse wrong");
  apb_ready_a :
    assert property (PSEL_IN && PENABLE_IN && !PREADY_OUT |=> PREADY_OUT ##1 !PREADY_OUT)
    else $error("bus answer wrong");
endmodule : pdm_ctrl_sva

// File: sim/pdm_pin_model.sv
// model: drivers of the interrupt, reset and standby pins
`timescale 1ns/100ps
module pdm_pin_model (
  input  wire logic  clk_in,
  output logic       nmi_n_out,
  output logic [2:0] req_n_out,
  output logic       rst_n_out,
  output logic       hw_standby_pin_n_n_out
);
  // pulled up pins idle high
  initial
  begin
    {nmi_n_out, req_n_out, rst_n_out, hw_standby_pin_n_n_out} = 6'h3F;
  end
  // pattern {nmi, req[2:0], reset, standby}, changed after an edge
  task automatic drive(input logic [5:0] v);
    @(posedge clk_in);
    {nmi_n_out, req_n_out, rst_n_out, hw_standby_pin_n_n_out} <= v;
  endtask : drive
  // reset held low past the longest settle count
  task automatic hold_reset(input int n);
    @(posedge clk_in);
    rst_n_out <= 1'b0;
    repeat (n) @(posedge clk_in);
    rst_n_out <= 1'b1;
  endtask : hold_reset
endmodule : pdm_pin_model

// File: sim/pdm_ctrl_tb.sv
// testbench: registers, sleep, standby and pin wake-ups
`timescale 1ns/100ps
module pdm_ctrl_tb;
  logic        clk, rst_n, psel, penable, pwrite, sleep, imask, pirq, rerr;
  logic        pready, pslverr, cpu_en, per_en, osc, wake, nmi_edge, nmi_n, rpin_n, hw_standby_pin_n_n;
  logic [2:0]  req_n, src, mode, reqen;
  logic [3:0]  strb;
  logic [5:0]  aux;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  int          fails = 0;
  int          checks_done = 0;
  int          edges = 0;
  pdm_ctrl #(.SETTLE_STATES_0(8), .SETTLE_STATES_1(16), .SETTLE_STATES_2(32),
    .SETTLE_STATES_3(64), .SETTLE_STATES_4(128)) dut (.CLK_IN(clk), .RESET_N_IN(rst_n),
    .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
    .PWDATA_IN(pwdata), .PSTRB_IN(strb), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
    .PSLVERR_OUT(pslverr), .SLEEP_EXEC_IN(sleep), .CPU_IMASK_IN(imask),
    .PERIPH_IRQ_IN(pirq), .EXT_REQ_ENABLE_IN(reqen), .NMI_PIN_N_IN(nmi_n),
    .EXT_REQUEST_N_IN(req_n), .RESET_PIN_N_IN(rpin_n), .HW_STANDBY_PIN_N_IN(hw_standby_pin_n_n),
    .CPU_CLK_EN_OUT(cpu_en), .PERIPH_CLK_EN_OUT(per_en), .OSC_RUN_OUT(osc),
    .PERIPH_INIT_OUT(aux[5]), .CPU_RESET_OUT(aux[4]), .PORT_HOLD_OUT(aux[3]),
    .PORT_HIZ_OUT(aux[2]), .WAKE_PULSE_OUT(wake), .WAKE_SRC_OUT(src),
    .NMI_EDGE_OUT(nmi_edge), .RAM_ENABLE_OUT(aux[1]), .DUAL_PORT_MEM_ENABLE_OUT(aux[0]),
    .MODE_OUT(mode));
  pdm_pin_model pins (.clk_in(clk), .nmi_n_out(nmi_n), .req_n_out(req_n),
    .rst_n_out(rpin_n), .hw_standby_pin_n_n_out(hw_standby_pin_n_n));
  always #20 clk = ~clk;
  always @(posedge clk)
    if (nmi_edge === 1'b1)
      edges++;
  // ==========
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [15:0] ad, input logic [31:0] wd);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk(32'(n < 20), 32'h1);
  endtask : apb
  task automatic wait_mode(input logic [2:0] m);
    int n;
    n = 0;
    while (mode !== m && n < 400)
    begin
      @(posedge clk);
      n++;
    end
    chk(32'(mode), 32'(m));
  endtask : wait_mode
  task automatic do_sleep;
    @(posedge clk);
    sleep <= 1'b1;
    @(posedge clk);
    sleep <= 1'b0;
  endtask : do_sleep
  // ==========
  // scenarios
  task automatic t_regs;
    apb(1'b0, 16'hFFC4, 32'h0);
    chk(rdata, 32'h09);
    apb(1'b1, 16'hFFC4, 32'hFFFFFFFF);
    apb(1'b0, 16'hFFC4, 32'h0);
    chk(rdata, 32'hFF);
    chk(32'(aux[1:0]), 32'h3);
    strb <= 4'h0;
    apb(1'b1, 16'hFFC4, 32'h0);
    strb <= 4'hF;
    apb(1'b0, 16'hFFC4, 32'h0);
    chk(rdata, 32'hFF);
    apb(1'b1, 16'hFFC4, 32'h0);
    apb(1'b0, 16'hFFC4, 32'h0);
    chk(rdata, 32'h08);
    apb(1'b0, 16'hFFC0, 32'h0);
    chk({rdata[30:0], rerr}, 32'h1);
  endtask : t_regs
  task automatic t_sleep;
    apb(1'b1, 16'hFFC4, 32'h09);
    do_sleep;
    wait_mode(3'h1);
    chk(32'({cpu_en, per_en, osc}), 32'h3);
    pirq <= 1'b1;
    wait_mode(3'h0);
    chk(32'({wake, src}), 32'hD);
    pirq <= 1'b0;
  endtask : t_sleep
  task automatic t_masked;
    imask <= 1'b1;
    do_sleep;
    wait_mode(3'h1);
    pirq <= 1'b1;
    repeat (20) @(posedge clk);
    chk(32'(mode), 32'h1);
    pins.drive(6'h1F);
    wait_mode(3'h0);
    chk(32'(src), 32'h1);
    {imask, pirq} <= 2'h0;
    pins.drive(6'h3F);
  endtask : t_masked
  task automatic t_edge;
    apb(1'b1, 16'hFFC4, 32'h0D);
    edges = 0;
    pins.drive(6'h1F);
    repeat (6) @(posedge clk);
    chk(32'(edges), 32'h0);
    pins.drive(6'h3F);
    repeat (6) @(posedge clk);
    chk(32'(edges), 32'h1);
    apb(1'b1, 16'hFFC4, 32'h8D);
    do_sleep;
    wait_mode(3'h2);
    pins.drive(6'h1F);
    repeat (10) @(posedge clk);
    chk(32'(mode), 32'h2);
    pins.drive(6'h3F);
    wait_mode(3'h0);
    chk(32'(src), 32'h1);
  endtask : t_edge
  task automatic t_settle;
    int n;
    logic [31:0] v;
    for (int s = 0; s < 8; s++)
    begin
      v = 32'h89 | (32'(s) << 4);
      apb(1'b1, 16'hFFC4, v);
      do_sleep;
      wait_mode(3'h2);
      chk(32'({cpu_en, per_en, osc, aux[5:2]}), 32'h0A);
      pins.drive(6'h3F & ~(6'h04 << (s % 3)));
      wait_mode(3'h3);
      n = 0;
      while (mode === 3'h3 && n < 300)
      begin
        @(posedge clk);
        n++;
      end
      chk(32'(n), (s > 3 ? 32'h80 : 32'h8 << s) + 32'h2);
      chk(32'({wake, src}), 32'h0A + 32'(s % 3));
      pins.drive(6'h3F);
      apb(1'b0, 16'hFFC4, 32'h0);
      chk(rdata, v);
    end
  endtask : t_settle
  task automatic t_reset;
    apb(1'b1, 16'hFFC4, 32'h89);
    do_sleep;
    wait_mode(3'h2);
    fork
      pins.hold_reset(150);
      begin
        wait_mode(3'h4);
        chk(32'({cpu_en, per_en, osc, aux[4]}), 32'hF);
      end
    join
    wait_mode(3'h0);
    apb(1'b0, 16'hFFC4, 32'h0);
    chk(rdata, 32'h09);
  endtask : t_reset
  task automatic t_hw(input logic [31:0] v, input logic [2:0] m);
    apb(1'b1, 16'hFFC4, v);
    do_sleep;
    wait_mode(m);
    pins.drive(6'h3E);
    wait_mode(3'h5);
    chk(32'(aux[5:2]), 32'hD);
    pins.drive(6'h3F);
    wait_mode(3'h6);
    pins.hold_reset(150);
    wait_mode(3'h0);
  endtask : t_hw
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : stop_test
  // ==========
  // main sequence and watchdog
  initial
  begin
    {clk, rst_n, psel, penable, pwrite, sleep, imask, pirq} = 8'h0;
    paddr = 16'h0;
    pwdata = 32'h0;
    {strb, reqen} = 7'h7F;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_regs;
    t_sleep;
    t_masked;
    t_edge;
    t_settle;
    t_reset;
    t_hw(32'h09, 3'h1);
    t_hw(32'h89, 3'h2);
    stop_test;
  end
  initial
  begin
    #400000;
    fails++;
    stop_test;
  end
endmodule : pdm_ctrl_tb
bind pdm_ctrl pdm_ctrl_sva #(.SETTLE_STATES_0(SETTLE_STATES_0),
  .SETTLE_STATES_1(SETTLE_STATES_1), .SETTLE_STATES_2(SETTLE_STATES_2),
  .SETTLE_STATES_3(SETTLE_STATES_3), .SETTLE_STATES_4(SETTLE_STATES_4)) sva (.CLK_IN,
  .RESET_N_IN, .PSEL_IN, .PENABLE_IN, .PWRITE_IN, .PADDR_IN, .PWDATA_IN, .PSTRB_IN,
  .PREADY_OUT, .RESET_PIN_N_IN, .HW_STANDBY_PIN_N_IN, .CPU_CLK_EN_OUT, .PERIPH_CLK_EN_OUT,
  .OSC_RUN_OUT, .PERIPH_INIT_OUT, .PORT_HOLD_OUT, .PORT_HIZ_OUT, .WAKE_PULSE_OUT, .MODE_OUT);
